// ---- logic/callout_delay_defs.vh ----
/*
 constants for the callout delay compensation block: register offsets,
 field positions, reset values, timing counts and result codes.
 assumes a 100 MHz clock; included by bare name.
*/
`ifndef CALLOUT_DELAY_DEFS_VH
`define CALLOUT_DELAY_DEFS_VH

// register offsets
`define REG_CONTROL         4'h0
`define REG_MANUAL_OFFSET   4'h1
`define REG_WINDOW_LOW      4'h2
`define REG_WINDOW_HIGH     4'h3
`define REG_STATUS          4'h4
`define REG_MEASURED_DELAY  4'h5
`define REG_ACTIVE_DELAY    4'h6
`define REG_CORRECTED_TIME  4'h7

// control fields
`define CTL_AUTO_ANSWER_BIT 0
`define CTL_SHARED_PORT_BIT 1
`define CTL_START_BIT       2
`define CTL_ABORT_BIT       3

// reset values
`define RST_MANUAL_OFFSET   10'h000
`define RST_WINDOW_LOW      10'h000
`define RST_WINDOW_HIGH     10'h001
`define RST_CONTROL         2'h0

// millisecond range limits
`define MS_MAX              10'h3E7
`define MS_MIN_NONZERO      10'h001

// timing
`define CLOCK_MHZ           100
`define MS_US               1000
`define CYCLES_PER_MS       (`CLOCK_MHZ * `MS_US)
`define ECHO_TIMEOUT_MS     16'h07D0

// result codes
`define RES_NO_CALL         4'h0
`define RES_NORMAL          4'h1
`define RES_CALL_FAILED     4'h4
`define RES_DELAY_WINDOW    4'h8
`define RES_IN_PROGRESS     4'h9

`endif

// ---- logic/ms_timebase.v ----
/*
 millisecond tick generator for the callout delay block.
 assumes a free-running clock and synchronous active-high reset.
*/
`timescale 1ns/100ps
module ms_timebase #(
	parameter CYCLES_PER_MS = 100000
) (
	// clock and reset
	input  wire clock,
	input  wire reset,
	// tick out
	output reg  ms_tick
);
	reg [31:0] count_reg;

	always @(posedge clock) begin
		if (reset) begin
			count_reg <= 32'h0000_0000;
			ms_tick   <= 1'b0;
		end else if (count_reg == CYCLES_PER_MS - 1) begin
			count_reg <= 32'h0000_0000;
			ms_tick   <= 1'b1;
		end else begin
			count_reg <= count_reg + 32'h0000_0001;
			ms_tick   <= 1'b0;
		end
	end
endmodule

// ---- logic/callout_delay_compensation.v ----
/*
 callout delay compensation: probes a remote time reference over the modem,
 times the echo in ms, halves it, applies a window check or manual offset,
 corrects received time and gates auto-answer.
 assumes a byte-wide modem transmit/receive path and a 100 MHz clock.
*/
`timescale 1ns/100ps
`include "callout_delay_defs.vh"
module callout_delay_compensation #(
	parameter CYCLES_PER_MS = `CYCLES_PER_MS,
	parameter TIME_WIDTH    = 32,
	parameter [7:0] PROBE_CHAR = 8'h55
) (
	// clock and reset
	input  wire                  clock,
	input  wire                  reset,
	// register port
	input  wire [3:0]            reg_addr,
	input  wire [31:0]           reg_wdata,
	input  wire                  reg_write,
	input  wire                  reg_read,
	output reg  [31:0]           reg_rdata,
	// modem character path
	output reg                   tx_valid,
	output reg  [7:0]            tx_data,
	input  wire                  tx_ready,
	input  wire                  rx_valid,
	input  wire [7:0]            rx_data,
	// time from the reference
	input  wire                  ref_time_valid,
	input  wire [TIME_WIDTH-1:0] ref_time_ms,
	// corrected input time
	output reg                   input_time_valid,
	output reg  [TIME_WIDTH-1:0] input_time_ms,
	// answer side
	input  wire                  local_time_valid,
	input  wire                  incoming_call,
	output reg                   answer_call,
	output reg                   refuse_call,
	output reg                   send_time_info,
	output reg                   send_call_failed,
	// status
	output reg  [3:0]            callout_result_status,
	output wire                  callout_busy
);
	// callout sequencer states
	localparam S_IDLE    = 3'd0;
	localparam S_PROBE   = 3'd1;
	localparam S_ECHO    = 3'd2;
	localparam S_TIME    = 3'd3;
	localparam S_JUDGE   = 3'd4;

	// clamp a written ms value to its legal range
	function [9:0] clamp_ms;
		input [31:0] value;
		input [9:0]  min_value;
		begin
			if (value[31:0] > {22'h00_0000, `MS_MAX})
				clamp_ms = `MS_MAX;
			else if (value[9:0] < min_value)
				clamp_ms = min_value;
			else
				clamp_ms = value[9:0];
		end
	endfunction

	// command strobe: a control write with one command bit set
	function control_strobe;
		input       write;
		input [3:0] addr;
		input       bit_value;
		begin
			control_strobe = write && (addr == `REG_CONTROL) && bit_value;
		end
	endfunction

	// widen a 10-bit ms field to the 16-bit delay width
	function [15:0] pad_ms;
		input [9:0] value;
		begin
			pad_ms = {6'h00, value};
		end
	endfunction

	// true when the delay sits in [low, high)
	function in_window;
		input [15:0] delay;
		input [9:0]  low;
		input [9:0]  high;
		begin
			in_window = (delay >= pad_ms(low)) && (delay < pad_ms(high));
		end
	endfunction

	// sequencer and configuration state
	reg [2:0]            state_reg;
	reg [2:0]            state_next;
	reg [9:0]            manual_delay_offset_setting;
	reg [9:0]            delay_window_low;
	reg [9:0]            delay_window_high;
	reg                  auto_answer_enable;
	reg                  shared_port_reg;
	// measurement and delivery
	reg [15:0]           loop_ms_reg;
	reg [15:0]           prop_delay_reg;
	reg [15:0]           active_delay_reg;
	reg                  last_callout_ok_reg;
	reg [TIME_WIDTH-1:0] held_time_reg;
	wire                 ms_tick;
	wire                 auto_mode;
	wire                 start_cmd;
	wire                 abort_cmd;
	wire                 window_reject;
	wire                 echo_seen;
	wire                 echo_timeout;
	wire                 answer_blocked;
	wire [TIME_WIDTH-1:0] corrected_time;

	ms_timebase #(
		.CYCLES_PER_MS (CYCLES_PER_MS)
	) u_timebase (
		.clock   (clock),
		.reset   (reset),
		.ms_tick (ms_tick)
	);

	assign auto_mode = (manual_delay_offset_setting == 10'h000);
	assign start_cmd = control_strobe(reg_write, reg_addr, reg_wdata[`CTL_START_BIT]);
	assign abort_cmd = control_strobe(reg_write, reg_addr, reg_wdata[`CTL_ABORT_BIT]);
	// reject from the low bound inclusive up to just below high; at/above high accepted
	assign window_reject = auto_mode &&
		in_window(prop_delay_reg, delay_window_low, delay_window_high);
	assign callout_busy = (state_reg != S_IDLE);
	assign echo_seen    = rx_valid && (rx_data == PROBE_CHAR);
	assign echo_timeout = (loop_ms_reg >= `ECHO_TIMEOUT_MS);
	// refuse when auto-answer is off, while busy, or on a shared port until a callout succeeds
	assign answer_blocked = !auto_answer_enable || callout_busy ||
		(shared_port_reg && !last_callout_ok_reg);
	// reference time plus active delay
	assign corrected_time = held_time_reg
		+ {{(TIME_WIDTH-16){1'b0}}, active_delay_reg};

	// configuration registers
	always @(posedge clock) begin
		if (reset) begin
			manual_delay_offset_setting <= `RST_MANUAL_OFFSET;
			delay_window_low            <= `RST_WINDOW_LOW;
			delay_window_high           <= `RST_WINDOW_HIGH;
			auto_answer_enable          <= 1'b0;
			shared_port_reg             <= 1'b0;
		end else if (reg_write) begin
			case (reg_addr)
				`REG_CONTROL: begin
					auto_answer_enable <= reg_wdata[`CTL_AUTO_ANSWER_BIT];
					shared_port_reg    <= reg_wdata[`CTL_SHARED_PORT_BIT];
				end
				`REG_MANUAL_OFFSET: begin
					// zero kept as auto; else 1..999
					if (reg_wdata == 32'h0000_0000)
						manual_delay_offset_setting <= 10'h000;
					else
						manual_delay_offset_setting <= clamp_ms(reg_wdata, `MS_MIN_NONZERO);
				end
				`REG_WINDOW_LOW: begin
					delay_window_low <= clamp_ms(reg_wdata, 10'h000);
				end
				`REG_WINDOW_HIGH: begin
					delay_window_high <= clamp_ms(reg_wdata, `MS_MIN_NONZERO);
				end
				default: begin
				end
			endcase
		end
	end

	// callout sequencer
	always @* begin
		state_next = state_reg;
		case (state_reg)
			S_IDLE: begin
				if (start_cmd)
					state_next = auto_mode ? S_PROBE : S_TIME;
			end
			S_PROBE: begin
				if (tx_ready)
					state_next = S_ECHO;
			end
			S_ECHO: begin
				if (echo_seen)
					state_next = S_TIME;
				else if (echo_timeout)
					state_next = S_IDLE;
			end
			S_TIME: begin
				if (ref_time_valid)
					state_next = S_JUDGE;
			end
			S_JUDGE: begin
				// rejected call redials at once
				state_next = window_reject ? S_PROBE : S_IDLE;
			end
			default: begin
				state_next = S_IDLE;
			end
		endcase
		if (abort_cmd)
			state_next = S_IDLE;
	end

	always @(posedge clock) begin
		if (reset) begin
			state_reg             <= S_IDLE;
			prop_delay_reg        <= 16'h0000;
			active_delay_reg      <= 16'h0000;
			held_time_reg         <= {TIME_WIDTH{1'b0}};
			input_time_valid      <= 1'b0;
			input_time_ms         <= {TIME_WIDTH{1'b0}};
			callout_result_status <= `RES_NO_CALL;
			last_callout_ok_reg   <= 1'b0;
		end else begin
			state_reg        <= state_next;
			input_time_valid <= 1'b0;
			case (state_reg)
				S_IDLE: begin
					if (start_cmd) begin
						callout_result_status <= `RES_IN_PROGRESS;
						last_callout_ok_reg   <= 1'b0;
					end
				end
				S_ECHO: begin
					// half the round trip, rounded down
					if (echo_seen)
						prop_delay_reg <= {1'b0, loop_ms_reg[15:1]};
					else if (echo_timeout)
						callout_result_status <= `RES_CALL_FAILED;
				end
				S_TIME: begin
					// manual offset replaces the measurement
					if (ref_time_valid) begin
						held_time_reg    <= ref_time_ms;
						active_delay_reg <= auto_mode ? prop_delay_reg
							: pad_ms(manual_delay_offset_setting);
					end
				end
				S_JUDGE: begin
					if (window_reject) begin
						callout_result_status <= `RES_DELAY_WINDOW;
					end else begin
						input_time_ms         <= corrected_time;
						input_time_valid      <= 1'b1;
						callout_result_status <= `RES_NORMAL;
						last_callout_ok_reg   <= 1'b1;
					end
				end
				default: begin
				end
			endcase
			if (abort_cmd && state_reg != S_IDLE)
				callout_result_status <= `RES_CALL_FAILED;
		end
	end

	// probe launcher, raised on the move into probe state
	always @(posedge clock) begin
		if (reset) begin
			tx_valid <= 1'b0;
			tx_data  <= 8'h00;
		end else begin
			tx_valid <= (state_next == S_PROBE);
			tx_data  <= PROBE_CHAR;
		end
	end

	// loop-back timer in ms, cleared while the probe waits
	always @(posedge clock) begin
		if (reset) begin
			loop_ms_reg <= 16'h0000;
		end else if (state_reg == S_PROBE) begin
			loop_ms_reg <= 16'h0000;
		end else if ((state_reg == S_ECHO) && ms_tick && (loop_ms_reg != 16'hFFFF)) begin
			loop_ms_reg <= loop_ms_reg + 16'h0001;
		end
	end

	// answer gating
	always @(posedge clock) begin
		if (reset) begin
			answer_call      <= 1'b0;
			refuse_call      <= 1'b0;
			send_time_info   <= 1'b0;
			send_call_failed <= 1'b0;
		end else begin
			answer_call      <= 1'b0;
			refuse_call      <= 1'b0;
			send_time_info   <= 1'b0;
			send_call_failed <= 1'b0;
			if (incoming_call) begin
				if (answer_blocked) begin
					refuse_call <= 1'b1;
				end else begin
					answer_call      <= 1'b1;
					send_time_info   <= local_time_valid;
					send_call_failed <= !local_time_valid;
				end
			end
		end
	end

	// register read, data one cycle later
	always @(posedge clock) begin
		if (reset) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_read) begin
			case (reg_addr)
				`REG_CONTROL: begin
					reg_rdata <= {29'h0000_0000, callout_busy, shared_port_reg, auto_answer_enable};
				end
				`REG_MANUAL_OFFSET: begin
					reg_rdata <= {22'h00_0000, manual_delay_offset_setting};
				end
				`REG_WINDOW_LOW: begin
					reg_rdata <= {22'h00_0000, delay_window_low};
				end
				`REG_WINDOW_HIGH: begin
					reg_rdata <= {22'h00_0000, delay_window_high};
				end
				`REG_STATUS: begin
					reg_rdata <= {27'h000_0000, last_callout_ok_reg, callout_result_status};
				end
				`REG_MEASURED_DELAY: begin
					reg_rdata <= {16'h0000, prop_delay_reg};
				end
				`REG_ACTIVE_DELAY: begin
					reg_rdata <= {16'h0000, active_delay_reg};
				end
				`REG_CORRECTED_TIME: begin
					reg_rdata <= input_time_ms;
				end
				default: begin
					reg_rdata <= 32'h0000_0000;
				end
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end
endmodule

// ---- verification/callout_chk.sv ----
/*
 port checker for the callout delay block, bound into every instance.
 assumes single clock, synchronous active-high reset, ports as declared.
*/
`timescale 1ns/100ps
module callout_chk #(
	parameter CYCLES_PER_MS = 100000,
	parameter TIME_WIDTH    = 32,
	parameter [7:0] PROBE_CHAR = 8'h55
) (
	// clock and reset
	input logic                  clock,
	input logic                  reset,
	// modem path
	input logic                  tx_valid,
	input logic [7:0]            tx_data,
	input logic                  tx_ready,
	input logic                  ref_time_valid,
	input logic [TIME_WIDTH-1:0] ref_time_ms,
	input logic                  input_time_valid,
	input logic [TIME_WIDTH-1:0] input_time_ms,
	// answer side
	input logic                  incoming_call,
	input logic                  local_time_valid,
	input logic                  answer_call,
	input logic                  refuse_call,
	input logic                  send_time_info,
	input logic                  send_call_failed,
	// status
	input logic [3:0]            callout_result_status,
	input logic                  callout_busy
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	// window rejection just reported
	sequence s_reject;
		$changed(callout_result_status) && callout_result_status == 4'h8;
	endsequence
	sequence s_retry;
		!input_time_valid ##[0:2] tx_valid;
	endsequence
	chk_probe_char: assert property (tx_valid |-> tx_data == PROBE_CHAR)
		else $error("probe character wrong");
	chk_probe_hold: assert property (tx_valid && !tx_ready |=> tx_valid)
		else $error("probe dropped before accept");
	chk_one_probe: assert property (tx_valid && tx_ready |=> !tx_valid [*2])
		else $error("second probe sent");
	chk_busy_probe: assert property (tx_valid |-> callout_busy)
		else $error("probe while idle");
	chk_time_fix: assert property (input_time_valid |-> $past(ref_time_valid, 2) &&
		input_time_ms - $past(ref_time_ms, 2) <= 999)
		else $error("corrected time wrong");
	chk_time_ok: assert property (input_time_valid |-> callout_result_status == 4'h1)
		else $error("time given without normal status");
	chk_reject_retry: assert property (s_reject |-> s_retry)
		else $error("reject without retry");
	chk_answer_cause: assert property (answer_call || refuse_call |-> $past(incoming_call))
		else $error("answer without call");
	chk_answer_one: assert property (incoming_call |=> answer_call ^ refuse_call)
		else $error("call not answered or refused");
	chk_failed_info: assert property (answer_call |-> send_time_info == $past(local_time_valid)
		&& send_call_failed == !$past(local_time_valid))
		else $error("wrong answer content");
endmodule
bind callout_delay_compensation callout_chk #(
	.CYCLES_PER_MS(CYCLES_PER_MS),
	.TIME_WIDTH(TIME_WIDTH),
	.PROBE_CHAR(PROBE_CHAR)
) u_chk (.*);

// ---- verification/ref_echo_model.sv ----
/*
 remote time reference: echoes the probe after a set delay, then sends time.
 assumes the caller holds tx_valid until tx_ready; push_time asks for time.
*/
`timescale 1ns/100ps
module ref_echo_model (
	// clock and reset
	input  logic        clock,
	input  logic        reset,
	// modem path
	input  logic        tx_valid,
	input  logic [7:0]  tx_data,
	output logic        tx_ready,
	output logic        rx_valid,
	output logic [7:0]  rx_data,
	output logic        ref_time_valid,
	output logic [31:0] ref_time_ms,
	// control from bench
	input  logic [15:0] echo,
	input  logic        push_time,
	input  logic [31:0] tv
);
	logic [7:0] ch;
	task send_time;
		@(posedge clock);
		ref_time_valid <= 1;
		ref_time_ms <= tv;
		@(posedge clock);
		ref_time_valid <= 0;
		ref_time_ms <= ~tv;
	endtask
	initial begin
		tx_ready = 0;
		rx_valid = 0;
		ref_time_valid = 0;
		rx_data = 0;
		ref_time_ms = 0;
		ch = 0;
		forever begin
			@(posedge clock);
			if (!reset && tx_valid === 1'b1) begin
				repeat (2) @(posedge clock);
				tx_ready <= 1;
				@(posedge clock);
				tx_ready <= 0;
				ch = tx_data;
				repeat (echo - 1) @(posedge clock);
				rx_valid <= 1;
				rx_data <= ch;
				@(posedge clock);
				rx_valid <= 0;
				rx_data <= ~ch;
				send_time;
			end else if (push_time === 1'b1) begin
				send_time;
			end
		end
	end
endmodule

// ---- verification/tb_top.sv ----
/*
 self-checking bench for the callout delay block with a remote reference model.
 assumes 10 cycles to the ms so echo delays are short.
*/
`timescale 1ns/100ps
module tb_top;
	logic clock = 0, reset = 1, reg_write = 0, reg_read = 0, push_time = 0;
	logic local_time_valid = 1, incoming_call = 0;
	logic [3:0] reg_addr = 0;
	logic [31:0] reg_wdata = 0, tv = 0;
	logic [15:0] echo = 16'h002D;
	wire [31:0] reg_rdata, input_time_ms, ref_time_ms;
	wire [7:0] tx_data, rx_data;
	wire [3:0] callout_result_status;
	wire tx_valid, tx_ready, rx_valid, ref_time_valid, input_time_valid, callout_busy;
	wire answer_call, refuse_call, send_time_info, send_call_failed;
	integer errors = 0, tests_run = 0, i;
	always #5 clock = ~clock;
	callout_delay_compensation #(.CYCLES_PER_MS(10)) dut (.*);
	ref_echo_model peer (.*);
	task close_out;
		if (errors == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1;
		@(posedge clock);
		reg_write <= 0;
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1;
		@(posedge clock);
		reg_read <= 0;
		#1 chk(reg_rdata, e);
	endtask
	task ring(input logic [3:0] e);
		@(posedge clock);
		incoming_call <= 1;
		@(posedge clock);
		incoming_call <= 0;
		#1 chk({answer_call, refuse_call, send_time_info, send_call_failed}, e);
	endtask
	task wt(input logic [31:0] e);
		for (i = 0; i < 3000 && input_time_valid !== 1'b1; i++) @(posedge clock) #1;
		chk(input_time_ms, e);
	endtask
	task ws(input logic [3:0] s);
		for (i = 0; i < 3000 && callout_result_status !== s; i++) @(posedge clock) #1;
		chk(callout_result_status, s);
	endtask
	initial begin
		#200_000;
		errors++;
		close_out;
	end
	initial begin
		repeat (8) @(posedge clock);
		reset <= 0;
		rd(4'h1, 32'h0);
		rd(4'h2, 32'h0);
		rd(4'h3, 32'h1);
		rd(4'h4, 32'h0);
		rd(4'h8, 32'h0);
		wr(4'h1, 32'h03E8);
		rd(4'h1, 32'h03E7);
		wr(4'h3, 32'h0);
		rd(4'h3, 32'h1);
		wr(4'h2, 32'h03E7);
		rd(4'h2, 32'h03E7);
		wr(4'h2, 32'h0);
		wr(4'h3, 32'h1);
		// manual offset 5 ms, no probe
		wr(4'h1, 32'h5);
		tv <= 32'h1000;
		wr(4'h0, 32'h4);
		@(posedge clock) push_time <= 1;
		@(posedge clock) push_time <= 0;
		wt(32'h1005);
		rd(4'h6, 32'h5);
		// automatic, 45 cycle loop gives 2 ms, at or above high bound
		wr(4'h1, 32'h0);
		tv <= 32'h2000;
		wr(4'h0, 32'h4);
		wt(32'h2002);
		rd(4'h5, 32'h2);
		rd(4'h4, 32'h11);
		ring(4'b0100);
		wr(4'h0, 32'h1);
		ring(4'b1010);
		local_time_valid <= 0;
		ring(4'b1001);
		local_time_valid <= 1;
		wr(4'h0, 32'h3);
		ring(4'b1010);
		// aborted callout leaves shared port refusing
		wr(4'h1, 32'h5);
		wr(4'h0, 32'h7);
		rd(4'h0, 32'h7);
		wr(4'h0, 32'hB);
		ws(4'h4);
		ring(4'b0100);
		// 2 ms inside window 1..5 rejected, retry with short loop accepted
		wr(4'h1, 32'h0);
		wr(4'h3, 32'h5);
		wr(4'h2, 32'h1);
		tv <= 32'h3000;
		wr(4'h0, 32'h4);
		ws(4'h8);
		echo <= 16'h0005;
		wt(32'h3000);
		close_out;
	end
endmodule
